//--- rfpll_defs.svh
// Register offsets, field positions, reset values and timing for the RF loop control block
`ifndef RFPLL_DEFS_SVH
`define RFPLL_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RFPLL_ADDR_LOOP_CONTROL 8'h34
`define RFPLL_ADDR_BLEED 8'h35
`define RFPLL_ADDR_LOCKDET 8'h36
`define RFPLL_ADDR_FASTSET 8'h37
`define RFPLL_ADDR_REFDIV 8'h38
`define RFPLL_ADDR_INTDIV 8'h39
`define RFPLL_ADDR_FRACLO 8'h3A
`define RFPLL_ADDR_FRACHI 8'h3B

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RFPLL_RST_LOOP_CONTROL 16'h0020
`define RFPLL_RST_BLEED 8'h00
`define RFPLL_RST_LOCKDET 16'h0000
`define RFPLL_RST_FASTSET 16'h0000
`define RFPLL_RST_REFDIV 8'h00
`define RFPLL_RST_INTDIV 16'h0080
`define RFPLL_RST_FRACLO 16'h0000
`define RFPLL_RST_FRACHI 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFPLL_LOOP_RES_BIT 9
`define RFPLL_LOOP_INV_BIT 4
`define RFPLL_BLD_EN_BIT 5
`define RFPLL_LD_EN_BIT 15
`define RFPLL_LD_RST_BIT 13
`define RFPLL_FS_EN_BIT 12

// ----------------------------------------
// Lock windows in ns, per code
// ----------------------------------------
`define RFPLL_WIN0_NS 7
`define RFPLL_WIN1_NS 10
`define RFPLL_WIN2_NS 15
`define RFPLL_WIN3_NS 20
`define RFPLL_WIN4_NS 30
`define RFPLL_WIN5_NS 50
`define RFPLL_WIN6_NS 70
`define RFPLL_WIN7_NS 100

`endif

//--- rfpll_pkg.sv
// Types shared by the RF loop control block
package rfpll_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } rfpll_wr_t;

  typedef struct packed {
    logic pumpInvert;
    logic [3:0] pumpCode;
    logic [4:0] pumpMult;
    logic bleedEnable;
    logic [4:0] bleedSetting;
  } rfpll_pump_t;

  typedef struct packed {
    logic fracMode16;
    logic [10:0] intDiv;
    logic [23:0] fracOffset;
  } rfpll_div_t;

  typedef enum logic [2:0] {
    RFPLL_LD_OFF = 3'b001,
    RFPLL_LD_UNLOCKED = 3'b010,
    RFPLL_LD_LOCKED = 3'b100
  } rfpll_ld_state_t;

endpackage

//--- rfpll_ref_divider.sv
// Reference clock enable from the master clock by a programmable ratio
`timescale 1ns/1ns
module rfpll_ref_divider
  import rfpll_pkg::*;
#(
  parameter int RATIO_W = 7
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [RATIO_W-1:0] ratio,
  output logic refTick
);

  logic [RATIO_W-1:0] count_reg;
  logic [RATIO_W-1:0] count_next;
  logic wrapNow;

  // Zero code wraps at all-ones, giving the largest ratio
  assign wrapNow = (count_reg == RATIO_W'(ratio - 1'b1));
  assign count_next = wrapNow ? '0 : RATIO_W'(count_reg + 1'b1);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= '0;
      refTick <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      refTick <= wrapNow;
    end
  end

endmodule

//--- rfpll_fast_timer.sv
// Fastlock duration timer: 4^coarse x fine system clock cycles
`timescale 1ns/1ns
module rfpll_fast_timer
  import rfpll_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] coarse,
  input wire logic [6:0] fine,
  output logic busy
);

  logic [21:0] remain_reg;
  logic [21:0] loadValue;
  logic [7:0] fineCount;

  // Zero fine code stands for 128
  assign fineCount = (fine == 7'h00) ? 8'h80 : {1'b0, fine};
  assign loadValue = 22'({14'h0000, fineCount} << {coarse, 1'b0});

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      remain_reg <= '0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      remain_reg <= loadValue;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      remain_reg <= 22'(remain_reg - 1'b1);
      busy <= (remain_reg != 22'h000001);
    end
  end

endmodule

//--- rfpll_divider_lock_fastlock.sv
// RF loop control: register file, pump settings, lock detector, fastlock, dividers
`timescale 1ns/1ns
`include "rfpll_defs.svh"

// How it works
// - Polarity bit 0 sinks when feedback is faster; 1 inverts.
// - Four-bit pump code gives 25 uA steps, 25 to 400 uA.
// - Bleed enable bit turns a constant bleed current on or off.
// - Bleed current is 3.125 uA times one plus the five-bit setting.
// - Lock detector runs only while enabled; cleared means power-save.
// - Reset-lock write pulses detector out of lock, clears status, self-clears.
// - Arrivals within the coded window, 7 to 100 ns, count as in phase.
// - Unlocked: lock after N consecutive in-phase, 1 to 32, zero means 32.
// - Locked: drop after N consecutive out-of-phase, 1 to 8, zero means 8.
// - Integer divider write in fastlock pulls pin low, boosts pump, starts timer.
// - Timer runs 4 to the coarse times fine cycles; zero fine means 128.
// - Fastlock multiplies pump current by 4, 8, 12 or 16.
// - Reference tick divides master clock by 1 to 128; zero means 128.
// - Integer divider updates apply while the loop runs.
// - 24-bit mode joins high and low fraction into one signed value.
// - Resolution bit 1 uses only the low 16-bit fraction.
module rfpll_divider_lock_fastlock
  import rfpll_pkg::*;
#(
  parameter int WIN_CNT_W = 5
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input rfpll_wr_t regWr,
  input wire logic phaseCompare,
  input wire logic [7:0] phaseErrorNs,
  output rfpll_pump_t pumpCtrl,
  output rfpll_div_t divCtrl,
  output logic divUpdate,
  output logic refTick,
  output logic lockDetPowerSave,
  output logic lockStatus,
  output logic fastSettlePinOut,
  output logic fastSettlePinOe,
  output logic fastSettleActive
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] loopControl_reg;
  logic [7:0] bleedCurrentCtrl_reg;
  logic [15:0] lockDetectorCtrl_reg;
  logic [15:0] fastSettleCtrl_reg;
  logic [7:0] referenceDivider_reg;
  logic [15:0] mainDividerInteger_reg;
  logic [15:0] mainFractionLow_reg;
  logic [7:0] mainFractionHigh_reg;

  wire hitCon = regWrite && (regWr.addr == `RFPLL_ADDR_LOOP_CONTROL);
  wire hitBleed = regWrite && (regWr.addr == `RFPLL_ADDR_BLEED);
  wire hitLd = regWrite && (regWr.addr == `RFPLL_ADDR_LOCKDET);
  wire hitFs = regWrite && (regWr.addr == `RFPLL_ADDR_FASTSET);
  wire hitRef = regWrite && (regWr.addr == `RFPLL_ADDR_REFDIV);
  wire hitInt = regWrite && (regWr.addr == `RFPLL_ADDR_INTDIV);
  wire hitFrLo = regWrite && (regWr.addr == `RFPLL_ADDR_FRACLO);
  wire hitFrHi = regWrite && (regWr.addr == `RFPLL_ADDR_FRACHI);

  // Reset-lock bit never stored, so it reads back as cleared
  wire resetLockPulse = hitLd && regWr.data[`RFPLL_LD_RST_BIT];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loopControl_reg <= `RFPLL_RST_LOOP_CONTROL;
      bleedCurrentCtrl_reg <= `RFPLL_RST_BLEED;
      lockDetectorCtrl_reg <= `RFPLL_RST_LOCKDET;
      fastSettleCtrl_reg <= `RFPLL_RST_FASTSET;
      referenceDivider_reg <= `RFPLL_RST_REFDIV;
      mainDividerInteger_reg <= `RFPLL_RST_INTDIV;
      mainFractionLow_reg <= `RFPLL_RST_FRACLO;
      mainFractionHigh_reg <= `RFPLL_RST_FRACHI;
    end
    else
    begin
      if (hitCon)
        loopControl_reg <= regWr.data;
      if (hitBleed)
        bleedCurrentCtrl_reg <= regWr.data[7:0];
      if (hitLd)
        lockDetectorCtrl_reg <= regWr.data & ~(16'h0001 << `RFPLL_LD_RST_BIT);
      if (hitFs)
        fastSettleCtrl_reg <= regWr.data;
      if (hitRef)
        referenceDivider_reg <= regWr.data[7:0];
      if (hitInt)
        mainDividerInteger_reg <= regWr.data;
      if (hitFrLo)
        mainFractionLow_reg <= regWr.data;
      if (hitFrHi)
        mainFractionHigh_reg <= regWr.data[7:0];
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire ldEnable = lockDetectorCtrl_reg[`RFPLL_LD_EN_BIT];
  wire [2:0] ldWindowCode = lockDetectorCtrl_reg[10:8];
  wire [2:0] lossCode = lockDetectorCtrl_reg[7:5];
  wire [4:0] lockCode = lockDetectorCtrl_reg[4:0];
  wire fsEnable = fastSettleCtrl_reg[`RFPLL_FS_EN_BIT];
  wire fracMode16 = loopControl_reg[`RFPLL_LOOP_RES_BIT];

  // Window in ns for a code; decoder kept as a function for reuse
  function automatic logic [7:0] windowNs(input logic [2:0] code);
    logic [7:0] w;
    w = 8'h00;
    case (code)
      3'h0: w = 8'(`RFPLL_WIN0_NS);
      3'h1: w = 8'(`RFPLL_WIN1_NS);
      3'h2: w = 8'(`RFPLL_WIN2_NS);
      3'h3: w = 8'(`RFPLL_WIN3_NS);
      3'h4: w = 8'(`RFPLL_WIN4_NS);
      3'h5: w = 8'(`RFPLL_WIN5_NS);
      3'h6: w = 8'(`RFPLL_WIN6_NS);
      default: w = 8'(`RFPLL_WIN7_NS);
    endcase
    return w;
  endfunction

  // Magnitude of phase error compared against the window
  wire inPhase = (phaseErrorNs <= windowNs(ldWindowCode));
  wire [5:0] lockTarget = (lockCode == 5'h00) ? 6'h20 : {1'b0, lockCode};
  wire [3:0] lossTarget = (lossCode == 3'h0) ? 4'h8 : {1'b0, lossCode};

  // ----------------------------------------
  // Lock detector
  // ----------------------------------------
  rfpll_ld_state_t ldState_reg;
  rfpll_ld_state_t ldState_next;
  logic [WIN_CNT_W:0] runCount_reg;
  logic [WIN_CNT_W:0] runCount_next;

  wire [WIN_CNT_W:0] runInc = (WIN_CNT_W+1)'(runCount_reg + 1'b1);

  always_comb
  begin
    ldState_next = ldState_reg;
    runCount_next = runCount_reg;
    case (ldState_reg)
      RFPLL_LD_OFF:
      begin
        runCount_next = '0;
        if (ldEnable)
          ldState_next = RFPLL_LD_UNLOCKED;
      end
      RFPLL_LD_UNLOCKED:
      begin
        if (phaseCompare)
        begin
          if (!inPhase)
            runCount_next = '0;
          else if (runInc == (WIN_CNT_W+1)'(lockTarget))
          begin
            runCount_next = '0;
            ldState_next = RFPLL_LD_LOCKED;
          end
          else
            runCount_next = runInc;
        end
      end
      RFPLL_LD_LOCKED:
      begin
        if (phaseCompare)
        begin
          if (inPhase)
            runCount_next = '0;
          else if (runInc == (WIN_CNT_W+1)'(lossTarget))
          begin
            runCount_next = '0;
            ldState_next = RFPLL_LD_UNLOCKED;
          end
          else
            runCount_next = runInc;
        end
      end
      default:
      begin
        ldState_next = RFPLL_LD_OFF;
        runCount_next = '0;
      end
    endcase
    // Disable and reset-lock override any count in progress
    if (!ldEnable)
    begin
      ldState_next = RFPLL_LD_OFF;
      runCount_next = '0;
    end
    else if (resetLockPulse)
    begin
      ldState_next = RFPLL_LD_UNLOCKED;
      runCount_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ldState_reg <= RFPLL_LD_OFF;
      runCount_reg <= '0;
    end
    else
    begin
      ldState_reg <= ldState_next;
      runCount_reg <= runCount_next;
    end
  end

  // ----------------------------------------
  // Fastlock
  // ----------------------------------------
  logic timerBusy;
  wire fastStart = hitInt && fsEnable;

  rfpll_fast_timer u_fast_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(fastStart),
    .coarse(fastSettleCtrl_reg[11:9]),
    .fine(fastSettleCtrl_reg[8:2]),
    .busy(timerBusy)
  );

  // Multiplier 4 x (code + 1) while boosted, else unity
  wire [4:0] boostMult = 5'({fastSettleCtrl_reg[1:0], 2'b00} + 5'h04);
  wire [4:0] multNext = timerBusy ? boostMult : 5'h01;

  // ----------------------------------------
  // Reference divider
  // ----------------------------------------
  rfpll_ref_divider #(
    .RATIO_W(7)
  ) u_ref_divider (
    .clk(clk),
    .rst_b(rst_b),
    .ratio(referenceDivider_reg[6:0]),
    .refTick(refTick)
  );

  // ----------------------------------------
  // Fraction select
  // ----------------------------------------
  // 16-bit mode sign-extends the low word so the offset keeps its sign
  wire [23:0] fracNext = fracMode16 ?
    {{8{mainFractionLow_reg[15]}}, mainFractionLow_reg} :
    {mainFractionHigh_reg, mainFractionLow_reg};

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pumpCtrl <= '{pumpInvert: 1'b0, pumpCode: 4'h0, pumpMult: 5'h01,
                    bleedEnable: 1'b0, bleedSetting: 5'h00};
      divCtrl <= '0;
      divUpdate <= 1'b0;
      lockDetPowerSave <= 1'b1;
      lockStatus <= 1'b0;
      fastSettlePinOut <= 1'b0;
      fastSettlePinOe <= 1'b0;
      fastSettleActive <= 1'b0;
    end
    else
    begin
      pumpCtrl.pumpInvert <= loopControl_reg[`RFPLL_LOOP_INV_BIT];
      pumpCtrl.pumpCode <= loopControl_reg[3:0];
      pumpCtrl.pumpMult <= multNext;
      pumpCtrl.bleedEnable <= bleedCurrentCtrl_reg[`RFPLL_BLD_EN_BIT];
      pumpCtrl.bleedSetting <= bleedCurrentCtrl_reg[4:0];
      divCtrl.fracMode16 <= fracMode16;
      divCtrl.intDiv <= mainDividerInteger_reg[10:0];
      divCtrl.fracOffset <= fracNext;
      divUpdate <= hitInt;
      lockDetPowerSave <= (ldState_next == RFPLL_LD_OFF);
      lockStatus <= (ldState_next == RFPLL_LD_LOCKED);
      // Open drain: output held low, only the enable toggles
      fastSettlePinOut <= 1'b0;
      fastSettlePinOe <= timerBusy;
      fastSettleActive <= timerBusy;
    end
  end

endmodule

//--- rfpll_host.sv
// Host model that writes the loop control registers
`timescale 1ns/1ns
`include "rfpll_defs.svh"
module rfpll_host
  import rfpll_pkg::*;
(
  input wire logic clk,
  output logic regWrite,
  output rfpll_wr_t regWr
);
  initial
  begin
    regWrite = 1'b0;
    regWr = '0;
  end

  // Integer values held within 32 to 2047 in every mode
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == `RFPLL_ADDR_LOOP_CONTROL)
      v[5] = 1'b1;
    if (a == `RFPLL_ADDR_INTDIV)
      v[15:11] = 5'h00;
    if (a == `RFPLL_ADDR_INTDIV && v[10:0] < 11'h020)
      v[10:0] = 11'h020;
    regWr = {a, v};
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    // Idle edge so back-to-back calls never re-drive the strobe in one step
    @(negedge clk);
  endtask
endmodule

//--- rfpll_chk.sv
// Port checker for the RF loop control block
`timescale 1ns/1ns
`include "rfpll_defs.svh"
module rfpll_chk
  import rfpll_pkg::*;
#(
  parameter int WIN_CNT_W = 5
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input rfpll_wr_t regWr,
  input wire logic phaseCompare,
  input wire logic [7:0] phaseErrorNs,
  input rfpll_pump_t pumpCtrl,
  input rfpll_div_t divCtrl,
  input wire logic divUpdate,
  input wire logic refTick,
  input wire logic lockDetPowerSave,
  input wire logic lockStatus,
  input wire logic fastSettlePinOut,
  input wire logic fastSettlePinOe,
  input wire logic fastSettleActive
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence intWrite;
    regWrite && regWr.addr == `RFPLL_ADDR_INTDIV;
  endsequence
  sequence regAt(logic [7:0] a);
    regWrite && regWr.addr == a;
  endsequence

  div_update_a: assert property (intWrite |=> divUpdate)
    else $error("divider update pulse missing");
  int_apply_a: assert property (
    intWrite |-> ##2 divCtrl.intDiv == $past(regWr.data[10:0], 2))
    else $error("integer divider not applied");
  pump_set_a: assert property (
    regAt(`RFPLL_ADDR_LOOP_CONTROL) |-> ##2
    {pumpCtrl.pumpInvert, pumpCtrl.pumpCode} == $past(regWr.data[4:0], 2))
    else $error("pump polarity or code wrong");
  bleed_set_a: assert property (
    regAt(`RFPLL_ADDR_BLEED) |-> ##2
    {pumpCtrl.bleedEnable, pumpCtrl.bleedSetting} == $past(regWr.data[5:0], 2))
    else $error("bleed setting wrong");
  power_save_a: assert property (
    regAt(`RFPLL_ADDR_LOCKDET) |-> ##2 lockDetPowerSave == !$past(regWr.data[15], 2))
    else $error("detector power-save wrong");
  lock_reset_a: assert property (
    regWrite && regWr.addr == `RFPLL_ADDR_LOCKDET && regWr.data[13] |-> ##[1:2] !lockStatus)
    else $error("reset lock did not clear status");
  lock_rise_a: assert property (
    $rose(lockStatus) |-> $past(phaseCompare) && $past(phaseErrorNs) <= 8'h64)
    else $error("lock without in-phase compare");
  fast_start_a: assert property (
    $rose(fastSettlePinOe) |-> $past(divUpdate) && fastSettleActive && !fastSettlePinOut)
    else $error("fastlock start wrong");
  fast_mult_a: assert property (
    fastSettleActive ? pumpCtrl.pumpMult inside {5'h04, 5'h08, 5'h0C, 5'h10}
    : pumpCtrl.pumpMult == 5'h01)
    else $error("pump multiplier wrong");
endmodule

bind rfpll_divider_lock_fastlock rfpll_chk #(.WIN_CNT_W(WIN_CNT_W)) chk (
  .clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regWr(regWr),
  .phaseCompare(phaseCompare), .phaseErrorNs(phaseErrorNs),
  .pumpCtrl(pumpCtrl), .divCtrl(divCtrl), .divUpdate(divUpdate),
  .refTick(refTick), .lockDetPowerSave(lockDetPowerSave), .lockStatus(lockStatus),
  .fastSettlePinOut(fastSettlePinOut), .fastSettlePinOe(fastSettlePinOe),
  .fastSettleActive(fastSettleActive)
);

//--- tb.sv
// Testbench for the RF loop control block
`timescale 1ns/1ns
`include "rfpll_defs.svh"
module tb
  import rfpll_pkg::*;
;
  logic clk;
  logic rst_b;
  logic regWrite;
  rfpll_wr_t regWr;
  logic phaseCompare;
  logic [7:0] phaseErrorNs;
  rfpll_pump_t pumpCtrl;
  rfpll_div_t divCtrl;
  logic divUpdate, refTick, lockDetPowerSave, lockStatus;
  logic fastSettlePinOut, fastSettlePinOe, fastSettleActive;
  int numErrors = 0;
  int samplesChecked = 0;
  int win[8] = '{7, 10, 15, 20, 30, 50, 70, 100};

  rfpll_host host (.clk(clk), .regWrite(regWrite), .regWr(regWr));
  rfpll_divider_lock_fastlock DUT (
    .clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regWr(regWr),
    .phaseCompare(phaseCompare), .phaseErrorNs(phaseErrorNs), .pumpCtrl(pumpCtrl),
    .divCtrl(divCtrl), .divUpdate(divUpdate), .refTick(refTick),
    .lockDetPowerSave(lockDetPowerSave), .lockStatus(lockStatus),
    .fastSettlePinOut(fastSettlePinOut), .fastSettlePinOe(fastSettlePinOe),
    .fastSettleActive(fastSettleActive)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic printVerdict;
    $display("Checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic limit(input bit hit);
    if (hit)
    begin
      numErrors++;
      printVerdict();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One compare pulse; status is settled when this returns
  task automatic cmp(input logic [7:0] err);
    phaseErrorNs = err;
    phaseCompare = 1'b1;
    @(negedge clk);
    phaseCompare = 1'b0;
    @(negedge clk);
  endtask

  task automatic tReset;
    chk("pumpRst", 36'h0040, pumpCtrl);
    chk("saveRst", 36'h1, lockDetPowerSave);
    chk("pinRst", 36'h0, fastSettlePinOe);
    rst_b = 1'b1;
    cyc(2);
    chk("divRst", 36'h080000000, divCtrl);
  endtask

  task automatic tPump;
    logic [15:0] con[2] = '{16'h0030, 16'h002F};
    logic [15:0] bld[2] = '{16'h002C, 16'h001F};
    for (int i = 0; i < 2; i++)
    begin
      host.wr(`RFPLL_ADDR_LOOP_CONTROL, con[i]);
      host.wr(`RFPLL_ADDR_BLEED, bld[i]);
      cyc(1);
      chk("pump", con[i][4:0], {pumpCtrl.pumpInvert, pumpCtrl.pumpCode});
      chk("bleed", bld[i][5:0], {pumpCtrl.bleedEnable, pumpCtrl.bleedSetting});
    end
  endtask

  task automatic tFrac;
    host.wr(`RFPLL_ADDR_FRACLO, 16'h8001);
    host.wr(`RFPLL_ADDR_FRACHI, 16'h0012);
    host.wr(`RFPLL_ADDR_LOOP_CONTROL, 16'h0020);
    cyc(1);
    chk("frac24", 36'h0128001, {divCtrl.fracMode16, divCtrl.fracOffset});
    host.wr(`RFPLL_ADDR_LOOP_CONTROL, 16'h0220);
    cyc(1);
    chk("frac16", 36'h1FF8001, {divCtrl.fracMode16, divCtrl.fracOffset});
  endtask

  task automatic tLock;
    host.wr(`RFPLL_ADDR_LOCKDET, 16'h8043);
    cyc(1);
    chk("powerSave", 36'h0, lockDetPowerSave);
    repeat (2) cmp(8'h07);
    cmp(8'h08);
    repeat (2) cmp(8'h07);
    chk("lockEarly", 36'h0, lockStatus);
    cmp(8'h07);
    chk("lockOn", 36'h1, lockStatus);
    cmp(8'hC8);
    cmp(8'h00);
    cmp(8'hC8);
    chk("lockHold", 36'h1, lockStatus);
    cmp(8'hC8);
    chk("lockLost", 36'h0, lockStatus);
    host.wr(`RFPLL_ADDR_LOCKDET, 16'h8000);
    repeat (31) cmp(8'h03);
    chk("lock31", 36'h0, lockStatus);
    cmp(8'h03);
    chk("lock32", 36'h1, lockStatus);
    repeat (7) cmp(8'h09);
    chk("loss7", 36'h1, lockStatus);
    cmp(8'h09);
    chk("loss8", 36'h0, lockStatus);
  endtask

  task automatic tWindow;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(`RFPLL_ADDR_LOCKDET, 16'hA021 | 16'(i << 8));
      chk("relock", 36'h0, lockStatus);
      cmp(8'(win[i] + 1));
      chk("outside", 36'h0, lockStatus);
      cmp(8'(win[i]));
      chk("inside", 36'h1, lockStatus);
    end
    host.wr(`RFPLL_ADDR_LOCKDET, 16'h0021);
    cyc(1);
    cmp(8'h00);
    chk("offSave", 36'h1, lockDetPowerSave);
    chk("offLock", 36'h0, lockStatus);
  endtask

  task automatic tFast;
    logic [15:0] cfg[4] = '{16'h1004, 16'h120D, 16'h1002, 16'h1E07};
    int dur[4] = '{1, 12, 128, 16384};
    int mult[4] = '{4, 8, 12, 16};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      host.wr(`RFPLL_ADDR_FASTSET, cfg[i]);
      host.wr(`RFPLL_ADDR_INTDIV, 16'h0100 + 16'(i));
      for (n = 0; n < 4 && fastSettlePinOe !== 1'b1; n++)
        @(negedge clk);
      limit(n == 4);
      chk("multOn", mult[i], pumpCtrl.pumpMult);
      chk("activeOn", 36'h1, fastSettleActive);
      for (n = 0; n < 20000 && fastSettlePinOe === 1'b1; n++)
        @(negedge clk);
      limit(n == 20000);
      chk("fastLen", dur[i], n);
      chk("multOff", 36'h1, pumpCtrl.pumpMult);
      chk("intDiv", 36'h100 + i, divCtrl.intDiv);
    end
    host.wr(`RFPLL_ADDR_FASTSET, 16'h01FC);
    host.wr(`RFPLL_ADDR_INTDIV, 16'h07FF);
    cyc(1);
    chk("pinIdle", 36'h0, fastSettlePinOe);
    chk("intMax", 36'h7FF, divCtrl.intDiv);
  endtask

  task automatic tRef;
    int ratio[3] = '{5, 128, 1};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      host.wr(`RFPLL_ADDR_REFDIV, 16'(ratio[i] % 128));
      // Let the old count run out before timing a period
      cyc(130);
      for (n = 0; n < 200 && refTick !== 1'b1; n++)
        @(negedge clk);
      limit(n == 200);
      @(negedge clk);
      for (n = 1; n < 200 && refTick !== 1'b1; n++)
        @(negedge clk);
      limit(n == 200);
      chk("refPeriod", ratio[i], n);
    end
  endtask

  initial
  begin
    rst_b = 1'b0;
    phaseCompare = 1'b0;
    phaseErrorNs = 8'h00;
    cyc(8);
    tReset();
    tPump();
    tFrac();
    tLock();
    tWindow();
    tFast();
    tRef();
    printVerdict();
  end
endmodule
